/* File: rtl/tpic_deadtime.sv */
/*
 Dead-time unit of one phase: holds both complementary outputs off
 while its counter runs down. Assumes trigger is a one-cycle strobe and
 tick a count enable, both synchronous to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module tpic_deadtime
   import tpic_pkg::*;
#(
   parameter int DT_W = 8
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // phase carrier
   tpic_dt_if.dt bus
);
   logic [DT_W-1:0] cnt_r;
   logic trig_eff;
   logic gap;

   assign trig_eff = bus.trigger && !bus.dt_disable && (bus.dt_value != '0);
   // a fresh trigger blanks at once so no overlap slips through
   assign gap = !bus.dt_disable && (trig_eff || (cnt_r != '0)); // see [RULE5]
   assign bus.busy = (cnt_r != '0);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         cnt_r <= '0;
      else if (trig_eff)
         cnt_r <= bus.dt_value; // see [RULE8]
      else if (bus.tick && (cnt_r != '0))
         cnt_r <= cnt_r - 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         bus.pos_act <= 1'b0;
         bus.neg_act <= 1'b0;
      end
      else
      begin
         bus.pos_act <= bus.drive && !gap; // see [RULE8]
         bus.neg_act <= !bus.drive && !gap;
      end
   end

   property p_trig_gap;
      @(posedge sys_clk) disable iff (!rst_b)
      trig_eff |=> !bus.pos_act && !bus.neg_act;
   endproperty
   a_trig_gap: assert property (p_trig_gap) else $error("no gap after trigger"); // see [RULE8]

   property p_nogap;
      @(posedge sys_clk) disable iff (!rst_b)
      bus.dt_disable |=> (bus.pos_act == $past(bus.drive)) && (bus.neg_act != $past(bus.drive));
   endproperty
   a_nogap: assert property (p_nogap) else $error("gap while disabled"); // see [RULE5]

   property p_gap_end;
      @(posedge sys_clk) disable iff (!rst_b)
      (cnt_r == 1) && bus.tick && !bus.trigger |=> !bus.busy;
   endproperty
   a_gap_end: assert property (p_gap_end) else $error("dead time overran"); // see [RULE8]
endmodule
`default_nettype wire

/* File: rtl/tpic_dt_if.sv */
/*
 Carrier between the control top and one dead-time phase unit.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface tpic_dt_if #(parameter int DT_W = 8);
   logic tick;
   logic trigger;
   logic drive;
   logic dt_disable;
   logic [DT_W-1:0] dt_value;
   logic pos_act;
   logic neg_act;
   logic busy;
   modport ctl (output tick, trigger, drive, dt_disable, dt_value,
                input pos_act, neg_act, busy);
   modport dt (input tick, trigger, drive, dt_disable, dt_value,
               output pos_act, neg_act, busy);
endinterface
`default_nettype wire

/* File: rtl/tpic_pkg.sv */
/*
 Constants and register map of the three-phase inverter control block.
 Assumes a 32-bit AXI4-Lite bus with byte addresses.
*/
// Contract
// [RULE1] start trigger: underflow, or underflow or write
// [RULE2] dead-time clock: undivided or divided by two
// [RULE3] carrier detect bit reads reload control level
// [RULE4] polarity bit: outputs active low or high
// [RULE5] disable bit removes the dead-time gap
// [RULE6] dead-time trigger: one-shot fall or output rise
// [RULE7] writes ignored unless write protect bit set
// [RULE8] active edges wait out the programmed dead time
package tpic_pkg;
   localparam int NUM_PHASES = 3;
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   // register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] PROT_OFF = 8'h04;
   localparam logic [7:0] DTVAL_OFF = 8'h08;
   localparam logic [7:0] STAT_OFF = 8'h0c;
   // three_phase_control_reg_1 fields
   localparam int START_SEL_BIT = 0;
   localparam int CLK_SEL_BIT = 2;
   localparam int CWD_BIT = 3;
   localparam int POL_BIT = 4;
   localparam int DT_DIS_BIT = 5;
   localparam int DT_TRIG_BIT = 6;
   localparam logic [7:0] CTRL_WR_MASK = 8'h75;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // protect register field
   localparam int PROT_BIT = 1;
   localparam logic PROT_RST = 1'b0;
   // status register fields
   localparam int STAT_POS_LSB = 0;
   localparam int STAT_NEG_LSB = 4;
   localparam int STAT_BUSY_LSB = 8;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/tpic_top.sv */
/*
 Three-phase inverter control top: AXI4-Lite register slave, start
 trigger, dead-time clock, trigger edge detect, polarity and outputs.
 Assumes all inputs are synchronous to sys_clk and the master keeps
 at most one write and one read outstanding.
*/
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module tpic_top
   import tpic_pkg::*;
#(
   parameter int DT_W = 8
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // axi4-lite write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   // axi4-lite write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [AXI_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // axi4-lite write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // axi4-lite read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   // axi4-lite read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [AXI_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // phase timer side
   input wire logic trig_underflow,
   input wire logic trig_timer_write,
   input wire logic reload_ctrl,
   input wire logic [NUM_PHASES-1:0] oneshot_pulse,
   input wire logic [NUM_PHASES-1:0] phase_drive,
   output logic phase_start,
   // gate driver outputs
   output logic [NUM_PHASES-1:0] phase_out_pos,
   output logic [NUM_PHASES-1:0] phase_out_neg
);
   logic aw_hold_r;
   logic [AXI_AW-1:0] awaddr_r;
   logic w_hold_r;
   logic [AXI_DW-1:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [AXI_DW-1:0] rdata_r;
   logic [1:0] rresp_r;
   logic wr_do;
   logic wr_mapped;
   logic rd_do;
   logic rd_mapped;
   logic [AXI_DW-1:0] rd_nxt;
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_rd;
   logic prot_r;
   logic [DT_W-1:0] dtval_r;
   logic cwd_r;
   logic div2_r;
   logic tick;
   logic start_r;
   logic [NUM_PHASES-1:0] drive_prev_r;
   logic [NUM_PHASES-1:0] oneshot_prev_r;
   logic [NUM_PHASES-1:0] dt_trig;
   logic [NUM_PHASES-1:0] pos_act;
   logic [NUM_PHASES-1:0] neg_act;
   logic [NUM_PHASES-1:0] dt_busy;
   logic [NUM_PHASES-1:0] out_pos_r;
   logic [NUM_PHASES-1:0] out_neg_r;

   // write channel: address and data taken in either order
   assign s_axi_awready = !aw_hold_r;
   assign s_axi_wready = !w_hold_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign wr_do = aw_hold_r && w_hold_r && !bvalid_r;
   assign wr_mapped = (awaddr_r[AXI_AW-1:4] == '0) && (awaddr_r[1:0] == 2'h0);

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         aw_hold_r <= 1'b0;
         awaddr_r <= '0;
      end
      else if (s_axi_awvalid && !aw_hold_r)
      begin
         aw_hold_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end
      else if (wr_do)
         aw_hold_r <= 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         w_hold_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= 4'h0;
      end
      else if (s_axi_wvalid && !w_hold_r)
      begin
         w_hold_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end
      else if (wr_do)
         w_hold_r <= 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else if (wr_do)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   // protect bit itself is always writable; all writable fields live in byte 0
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         prot_r <= PROT_RST;
      else if (wr_do && wr_mapped && wstrb_r[0] && (awaddr_r == PROT_OFF))
         prot_r <= wdata_r[PROT_BIT];
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         ctrl_r <= CTRL_RST;
      else if (wr_do && wstrb_r[0] && prot_r && (awaddr_r == CTRL_OFF)) // see [RULE7]
         ctrl_r <= wdata_r[7:0] & CTRL_WR_MASK;
   end

   // dead-time value shares the same protection as the control bits
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         dtval_r <= '0;
      else if (wr_do && wstrb_r[0] && prot_r && (awaddr_r == DTVAL_OFF)) // see [RULE7]
         dtval_r <= wdata_r[DT_W-1:0];
   end

   // read channel
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign rd_do = s_axi_arvalid && !rvalid_r;
   assign rd_mapped = (s_axi_araddr[AXI_AW-1:4] == '0) && (s_axi_araddr[1:0] == 2'h0);

   always_comb
   begin
      ctrl_rd = ctrl_r;
      ctrl_rd[CWD_BIT] = cwd_r; // see [RULE3]
      rd_nxt = '0;
      unique case (s_axi_araddr)
         CTRL_OFF: rd_nxt[7:0] = ctrl_rd;
         PROT_OFF: rd_nxt[PROT_BIT] = prot_r;
         DTVAL_OFF: rd_nxt[DT_W-1:0] = dtval_r;
         STAT_OFF:
         begin
            rd_nxt[STAT_POS_LSB +: NUM_PHASES] = out_pos_r;
            rd_nxt[STAT_NEG_LSB +: NUM_PHASES] = out_neg_r;
            rd_nxt[STAT_BUSY_LSB +: NUM_PHASES] = dt_busy;
         end
         default: rd_nxt = '0;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end
      else if (rd_do)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_nxt;
         rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   // carrier detect mirrors the reload control level
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         cwd_r <= 1'b0;
      else
         cwd_r <= reload_ctrl; // see [RULE3]
   end

   // phase timer start strobe
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         start_r <= 1'b0;
      else
         start_r <= trig_underflow || (ctrl_r[START_SEL_BIT] && trig_timer_write); // see [RULE1]
   end
   assign phase_start = start_r;

   // dead-time count rate: every cycle, or every second cycle
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         div2_r <= 1'b0;
      else
         div2_r <= !div2_r;
   end
   assign tick = ctrl_r[CLK_SEL_BIT] ? div2_r : 1'b1; // see [RULE2]

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         drive_prev_r <= '0;
         oneshot_prev_r <= '0;
      end
      else
      begin
         drive_prev_r <= phase_drive;
         oneshot_prev_r <= oneshot_pulse;
      end
   end

   // a change of drive is a rising edge of the true or the inverted shift output
   assign dt_trig = ctrl_r[DT_TRIG_BIT] ? (phase_drive ^ drive_prev_r)
                                        : (oneshot_prev_r & ~oneshot_pulse); // see [RULE6]

   for (genvar i = 0; i < NUM_PHASES; i++)
   begin : g_phase
      tpic_dt_if #(.DT_W(DT_W)) dt_bus ();
      assign dt_bus.tick = tick;
      assign dt_bus.trigger = dt_trig[i];
      assign dt_bus.drive = phase_drive[i];
      assign dt_bus.dt_disable = ctrl_r[DT_DIS_BIT]; // see [RULE5]
      assign dt_bus.dt_value = dtval_r;
      assign pos_act[i] = dt_bus.pos_act;
      assign neg_act[i] = dt_bus.neg_act;
      assign dt_busy[i] = dt_bus.busy;
      tpic_deadtime #(.DT_W(DT_W)) u_dt (
         .sys_clk(sys_clk),
         .rst_b(rst_b),
         .bus(dt_bus.dt)
      );
   end

   // reset leaves the drivers at the inactive level of active-low polarity
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         out_pos_r <= '1;
         out_neg_r <= '1;
      end
      else if (ctrl_r[POL_BIT])
      begin
         out_pos_r <= pos_act; // see [RULE4]
         out_neg_r <= neg_act;
      end
      else
      begin
         out_pos_r <= ~pos_act; // see [RULE4]
         out_neg_r <= ~neg_act;
      end
   end
   assign phase_out_pos = out_pos_r;
   assign phase_out_neg = out_neg_r;

   property p_start_under;
      @(posedge sys_clk) disable iff (!rst_b)
      trig_underflow |=> phase_start;
   endproperty
   a_start_under: assert property (p_start_under) else $error("underflow did not start"); // see [RULE1]

   property p_start_sel0;
      @(posedge sys_clk) disable iff (!rst_b)
      !ctrl_r[START_SEL_BIT] && !trig_underflow |=> !phase_start;
   endproperty
   a_start_sel0: assert property (p_start_sel0) else $error("write started timers"); // see [RULE1]

   property p_start_sel1;
      @(posedge sys_clk) disable iff (!rst_b)
      ctrl_r[START_SEL_BIT] && trig_timer_write |=> phase_start;
   endproperty
   a_start_sel1: assert property (p_start_sel1) else $error("write start missed"); // see [RULE1]

   property p_protect;
      @(posedge sys_clk) disable iff (!rst_b)
      wr_do && !prot_r |=> $stable(ctrl_r) && $stable(dtval_r);
   endproperty
   a_protect: assert property (p_protect) else $error("protected write landed"); // see [RULE7]

   property p_cwd;
      @(posedge sys_clk) disable iff (!rst_b)
      rd_do && (s_axi_araddr == CTRL_OFF) |=> s_axi_rdata[CWD_BIT] == $past(reload_ctrl, 2);
   endproperty
   a_cwd: assert property (p_cwd) else $error("carrier bit wrong"); // see [RULE3]

   property p_tick_div2;
      @(posedge sys_clk) disable iff (!rst_b)
      ctrl_r[CLK_SEL_BIT] && $stable(ctrl_r) |-> tick != $past(tick);
   endproperty
   a_tick_div2: assert property (p_tick_div2) else $error("half rate tick wrong"); // see [RULE2]

   property p_tick_full;
      @(posedge sys_clk) disable iff (!rst_b)
      !ctrl_r[CLK_SEL_BIT] |-> tick;
   endproperty
   a_tick_full: assert property (p_tick_full) else $error("full rate tick missing"); // see [RULE2]

   property p_pol;
      @(posedge sys_clk) disable iff (!rst_b)
      rst_b && $past(rst_b) |-> phase_out_pos[0] == ($past(pos_act[0]) ~^ $past(ctrl_r[POL_BIT]));
   endproperty
   a_pol: assert property (p_pol) else $error("polarity wrong"); // see [RULE4]

   // a drive change must really start the count and blank leg U
   property p_trig_sel1;
      @(posedge sys_clk) disable iff (!rst_b)
      ctrl_r[DT_TRIG_BIT] && !ctrl_r[DT_DIS_BIT] && (dtval_r != '0)
         && (phase_drive[0] != drive_prev_r[0]) |=> dt_busy[0] && !pos_act[0] && !neg_act[0];
   endproperty
   a_trig_sel1: assert property (p_trig_sel1) else $error("edge trigger missed"); // see [RULE6]
endmodule
`default_nettype wire

/* File: verification/test_three_phase_inverter_control.sv */
/*
 Self-checking bench of the three-phase inverter control block.
 Assumes the slave answers every bus request within 40 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module test_three_phase_inverter_control
   import tpic_pkg::*;
;
   localparam int DTV = 4;
   logic sys_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, st;
   logic [5:0] oe;
   logic [3:0] s_axi_wstrb;
   logic [2:0] s_axi_awprot, s_axi_arprot, oneshot_pulse, phase_drive, phase_out_pos, phase_out_neg;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic trig_underflow, trig_timer_write, reload_ctrl, phase_start, pol, gm_en;
   logic [15:0] lfsr;
   int num_errors, n_checks, shoots, g1, g2, i;

   tpic_top #(.DT_W(8)) i_dut (.sys_clk, .rst_b, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .trig_underflow, .trig_timer_write, .reload_ctrl,
      .oneshot_pulse, .phase_drive, .phase_start, .phase_out_pos, .phase_out_neg);

   tpic_gate_model i_gate (.sys_clk, .gate_pos(phase_out_pos), .gate_neg(phase_out_neg),
      .act_high(pol), .chk_en(gm_en), .shoot_cnt(shoots));

   function automatic logic [15:0] lfsr_nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [31:0] ctl_exp(input logic [7:0] d, input logic rl);
      return 32'(d & CTRL_WR_MASK) | (32'(rl) << CWD_BIT);
   endfunction

   // returns {neg, pos} for a gap-free leg
   function automatic logic [5:0] out_exp(input logic [2:0] dv, input logic p);
      return p ? {~dv, dv} : {dv, ~dv};
   endfunction

   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tmo;
      num_errors++;
      $display("[ERR] %0t bus wait ran out", $time);
      end_sim;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge sys_clk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
            break;
      end
      if (n == 40)
         tmo;
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // let an edge pass so a following call never re-drives bready in this step
      @(posedge sys_clk);
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge sys_clk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      if (n == 40)
         tmo;
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      axw(a, d, rsp);
      chk(rsp, RESP_OKAY);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      axr(a, rd, rsp);
      chk(rsp, RESP_OKAY);
      chk(rd, e);
   endtask

   task automatic pstart(input logic u, input logic w, input logic e);
      @(posedge sys_clk);
      trig_underflow <= u;
      trig_timer_write <= w;
      @(posedge sys_clk);
      trig_underflow <= 1'b0;
      trig_timer_write <= 1'b0;
      @(posedge sys_clk);
      chk(phase_start, e);
      @(posedge sys_clk);
      chk(phase_start, 1'b0);
   endtask

   // counts cycles with leg U fully off after a drive change or one-shot fall
   task automatic gap(input logic [2:0] dv, input logic ev, output int g);
      g = 0;
      if (ev)
         phase_drive <= dv;
      else
         oneshot_pulse <= 3'h0;
      repeat (40)
      begin
         @(posedge sys_clk);
         if (phase_out_pos[0] === ~pol && phase_out_neg[0] === ~pol)
            g++;
      end
      oneshot_pulse <= 3'h7;
   endtask

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {s_axi_awprot, s_axi_arprot, trig_underflow, trig_timer_write, reload_ctrl} = 9'h000;
      s_axi_wstrb = 4'hf;
      oneshot_pulse = 3'h7;
      phase_drive = 3'h0;
      {rst_b, pol, gm_en} = 3'h0;
      lfsr = 16'h7909;
      num_errors = 0;
      n_checks = 0;
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      chk({phase_out_neg, phase_out_pos}, 6'h3f);
      rdchk(CTRL_OFF, 32'h0);
      rdchk(PROT_OFF, 32'h0);
      wr(CTRL_OFF, 32'h75);
      rdchk(CTRL_OFF, 32'h0);
      wr(DTVAL_OFF, 32'h09);
      rdchk(DTVAL_OFF, 32'h0);
      wr(PROT_OFF, 32'h2);
      for (i = 0; i < 8; i++)
      begin
         lfsr = lfsr_nxt(lfsr);
         wr(CTRL_OFF, {16'h0, lfsr});
         rdchk(CTRL_OFF, ctl_exp(lfsr[7:0], 1'b0));
      end
      axr(8'h10, rd, rsp);
      chk(rd, 32'h0);
      chk(rsp, RESP_SLVERR);
      axw(8'h20, 32'h0, rsp);
      chk(rsp, RESP_SLVERR);
      wr(CTRL_OFF, 32'h0);
      pstart(1'b1, 1'b0, 1'b1);
      pstart(1'b0, 1'b1, 1'b0);
      wr(CTRL_OFF, 32'h1);
      pstart(1'b0, 1'b1, 1'b1);
      pstart(1'b1, 1'b0, 1'b1);
      for (i = 0; i < 2; i++)
      begin
         reload_ctrl <= i[0];
         repeat (2) @(posedge sys_clk);
         rdchk(CTRL_OFF, ctl_exp(8'h01, i[0]));
      end
      // dead time off: outputs follow the drive through the polarity
      for (i = 0; i < 8; i++)
      begin
         wr(CTRL_OFF, i[0] ? 32'h30 : 32'h20);
         pol <= i[0];
         lfsr = lfsr_nxt(lfsr);
         phase_drive <= lfsr[2:0];
         repeat (4) @(posedge sys_clk);
         oe = out_exp(lfsr[2:0], i[0]);
         chk({phase_out_neg, phase_out_pos}, oe);
         // status mirrors both output levels; no leg is counting while disabled
         st = (32'(oe[2:0]) << STAT_POS_LSB) | (32'(oe[5:3]) << STAT_NEG_LSB);
         rdchk(STAT_OFF, st);
      end
      wr(DTVAL_OFF, DTV);
      rdchk(DTVAL_OFF, DTV);
      wr(CTRL_OFF, 32'h50);
      gm_en <= 1'b1;
      gap(~phase_drive, 1'b1, g1);
      chk(g1 >= DTV && g1 <= DTV + 2, 1'b1);
      wr(CTRL_OFF, 32'h54);
      gap(~phase_drive, 1'b1, g2);
      chk(g2 >= 2 * DTV && g2 <= 2 * DTV + 3, 1'b1);
      wr(CTRL_OFF, 32'h10);
      gap(~phase_drive, 1'b1, g1);
      chk(g1, 32'h0);
      gap(phase_drive, 1'b0, g1);
      chk(g1 >= DTV && g1 <= DTV + 2, 1'b1);
      wr(CTRL_OFF, 32'h70);
      gap(~phase_drive, 1'b1, g1);
      chk(g1, 32'h0);
      wr(PROT_OFF, 32'h0);
      wr(CTRL_OFF, 32'h75);
      rdchk(CTRL_OFF, ctl_exp(8'h70, 1'b1));
      chk(shoots, 32'h0);
      end_sim;
   end
endmodule
`default_nettype wire

/* File: verification/tpic_gate_model.sv */
/*
 Gate driver stand-in for the three inverter legs: counts every cycle
 in which both switches of a leg would be on at once.
 Assumes the bench holds chk_en low while the polarity setting moves.
*/
`timescale 1ns/10ps
`default_nettype none
module tpic_gate_model
   import tpic_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // gate inputs
   input wire logic [NUM_PHASES-1:0] gate_pos,
   input wire logic [NUM_PHASES-1:0] gate_neg,
   input wire logic act_high,
   input wire logic chk_en,
   // result
   output var int shoot_cnt
);
   logic [NUM_PHASES-1:0] both_on;
   assign both_on = act_high ? (gate_pos & gate_neg) : (~gate_pos & ~gate_neg);
   initial shoot_cnt = 0;
   // a leg with both switches on shorts the supply rail
   always @(posedge sys_clk)
      if (chk_en === 1'b1 && both_on !== 3'h0)
         shoot_cnt <= shoot_cnt + 1;
endmodule
`default_nettype wire
